// ===== fdc_pkg.sv
// fdc_pkg: shared constants and types for the floppy controller pin interface
package fdc_pkg;
	localparam int CLK_MHZ = 20;

	// register locations on the two address inputs
	localparam logic [1:0] ADDR_CMD_STAT = 2'h0;
	localparam logic [1:0] ADDR_TRACK    = 2'h1;
	localparam logic [1:0] ADDR_SECTOR   = 2'h2;
	localparam logic [1:0] ADDR_DATA     = 2'h3;

	// command opcodes in the upper nibble of command_entry
	localparam logic [3:0] CMD_RESTORE  = 4'h0;
	localparam logic [3:0] CMD_SEEK     = 4'h1;
	localparam logic [3:0] CMD_STEP_IN  = 4'h2;
	localparam logic [3:0] CMD_STEP_OUT = 4'h3;
	localparam logic [3:0] CMD_READ     = 4'h8;
	localparam logic [3:0] CMD_WRITE    = 4'hA;
	localparam logic [3:0] CMD_FORCE    = 4'hD;

	// host_status bit positions
	localparam int ST_BUSY  = 0;
	localparam int ST_DRQ   = 1;
	localparam int ST_LOST  = 2;
	localparam int ST_TRK0  = 3;
	localparam int ST_INDEX = 4;
	localparam int ST_WPROT = 6;
	localparam int ST_MOTOR = 7;

	// values after reset
	localparam logic [7:0] REG_RST = 8'h00;

	// times in their own units, cycle counts derived from the clock rate
	localparam int STEP_PULSE_NS  = 4000;
	localparam int STEP_PULSE_CYC = (STEP_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int STEP_RATE_US   = 6000;
	localparam int STEP_RATE_CYC  = STEP_RATE_US * CLK_MHZ;
	localparam int SPINUP_US      = 1000;
	localparam int SPINUP_CYC     = SPINUP_US * CLK_MHZ;
	localparam int FM_HALF_NS     = 4000;
	localparam int MFM_HALF_NS    = 2000;
	localparam int WPULSE_NS      = 500;
	localparam logic [6:0] FM_HALF_CYC  = 7'(FM_HALF_NS * CLK_MHZ / 1000);
	localparam logic [6:0] MFM_HALF_CYC = 7'(MFM_HALF_NS * CLK_MHZ / 1000);
	localparam logic [3:0] WPULSE_CYC   = 4'(WPULSE_NS * CLK_MHZ / 1000);
	localparam int SECTOR_BYTES   = 128;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'h0,
		ST_SPIN   = 3'h1,
		ST_STEP   = 3'h3,
		ST_SETTLE = 3'h2,
		ST_READ   = 3'h6,
		ST_WRDRQ  = 3'h7,
		ST_WRITE  = 3'h5,
		ST_DONE   = 3'h4
	} fdc_state_t;
endpackage : fdc_pkg

// ===== fdc_enc_if.sv
// fdc_enc_if: link between the controller and the write pulse encoder
`timescale 1ns/1ps
interface fdc_enc_if;
	logic       en;
	logic       mfm;
	logic [7:0] next_byte;
	logic       take;
	logic       pulse;
	modport ctl (output en, output mfm, output next_byte, input take, input pulse);
	modport enc (input en, input mfm, input next_byte, output take, output pulse);
endinterface : fdc_enc_if

// ===== fdc_sync.sv
// fdc_sync: two flip-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
module fdc_sync #(
	parameter int            W   = 1,
	parameter logic [W-1:0]  RST = '0
) (
	input  wire logic         clk_i,
	input  wire logic         nrst_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			meta_reg <= RST;
			q_o      <= RST;
		end else begin
			meta_reg <= d_i;
			q_o      <= meta_reg;
		end
	end
endmodule : fdc_sync

// ===== fdc_wenc.sv
// fdc_wenc: serialises bytes into fm or mfm clock and data pulses
`timescale 1ns/1ps
module fdc_wenc (
	input  wire logic clk_i,
	input  wire logic nrst_i,
	fdc_enc_if.enc    enc
);
	logic [7:0] shift_reg;
	logic [2:0] bit_reg;
	logic [6:0] hc_reg;
	logic [6:0] half;
	logic       ph_reg;
	logic       prev_reg;
	logic       run_reg;
	logic [3:0] pw_reg;
	logic       fire;
	logic       cell_end;

	assign half     = enc.mfm ? fdc_pkg::MFM_HALF_CYC : fdc_pkg::FM_HALF_CYC;
	assign cell_end = (hc_reg == half - 7'h01);
	// mfm drops the clock pulse unless two zero bits meet
	assign fire = ph_reg ? shift_reg[7] : (enc.mfm ? (!prev_reg && !shift_reg[7]) : 1'b1);
	assign enc.take  = enc.en && (!run_reg || (cell_end && ph_reg && bit_reg == 3'h7));
	assign enc.pulse = (pw_reg != 4'h0);

	always_ff @(posedge clk_i) begin
		if (!nrst_i || !enc.en) begin
			run_reg   <= 1'b0;
			shift_reg <= 8'h00;
			bit_reg   <= 3'h0;
			hc_reg    <= 7'h00;
			ph_reg    <= 1'b0;
			prev_reg  <= 1'b0;
		end else if (!run_reg) begin
			run_reg   <= 1'b1;
			shift_reg <= enc.next_byte;
		end else if (cell_end) begin
			hc_reg <= 7'h00;
			ph_reg <= !ph_reg;
			if (ph_reg) begin
				prev_reg  <= shift_reg[7];
				bit_reg   <= bit_reg + 3'h1;
				shift_reg <= (bit_reg == 3'h7) ? enc.next_byte : {shift_reg[6:0], 1'b0};
			end
		end else begin
			hc_reg <= hc_reg + 7'h01;
		end
	end

	// fixed-width pulse at the start of each window where fire is set
	always_ff @(posedge clk_i) begin
		if (!nrst_i || !enc.en) begin
			pw_reg <= 4'h0;
		end else if (run_reg && hc_reg == 7'h00 && fire && pw_reg == 4'h0) begin
			pw_reg <= fdc_pkg::WPULSE_CYC;
		end else if (pw_reg != 4'h0) begin
			pw_reg <= pw_reg - 4'h1;
		end
	end
endmodule : fdc_wenc

// ===== fdc_top.sv
// fdc_top: floppy controller host port, command sequencer and drive pins
`timescale 1ns/1ps
module fdc_top #(
	parameter int STEP_RATE_CYC = fdc_pkg::STEP_RATE_CYC,
	parameter int SPINUP_CYC    = fdc_pkg::SPINUP_CYC,
	parameter int SECTOR_BYTES  = fdc_pkg::SECTOR_BYTES
) (
	input  wire logic       clk_i,
	input  wire logic       nrst_i,
	input  wire logic       cs_n_i,
	input  wire logic       rw_i,
	input  wire logic [1:0] addr_i,
	input  wire logic [7:0] host_data_lines_i,
	output logic      [7:0] host_data_lines_o,
	output logic            host_data_lines_oe_o,
	output logic            data_request_flag_o,
	output logic            command_done_irq_o,
	output logic            step_o,
	output logic            head_direction_o,
	output logic            spindle_enable_o,
	output logic            write_gate_o,
	output logic            disk_write_pulses_o,
	input  wire logic       raw_read_n_i,
	input  wire logic       track_zero_sense_n_i,
	input  wire logic       index_hole_sense_n_i,
	input  wire logic       write_protect_sense_n_i,
	input  wire logic       density_select_i
);
	fdc_pkg::fdc_state_t state_reg;

	logic [11:0] bus_s;
	logic [4:0]  drv_s;
	logic        cs_n_s;
	logic        rw_s;
	logic [1:0]  addr_s;
	logic [7:0]  din_s;
	logic        raw_n_s;
	logic        trk0_hit;
	logic        index_hit;
	logic        wp_n_s;
	logic        mfm;
	logic        cs_n_d_reg;
	logic        raw_n_d_reg;
	logic        acc;
	logic        rd_stat;
	logic        wr_cmd;
	logic        rd_dat;
	logic        wr_dat;
	logic        cmd_go;
	logic [3:0]  op;
	logic [3:0]  new_op;
	logic [7:0]  command_entry_reg;
	logic [7:0]  head_track_number_reg;
	logic [7:0]  target_sector_number_reg;
	logic [7:0]  data_holding_reg;
	logic [7:0]  host_status;
	logic [19:0] timer_reg;
	logic [10:0] cnt_reg;
	logic        stepped_reg;
	logic        dir_reg;
	logic        need_step;
	logic        dir_next;
	logic        step_go;
	logic        drq_reg;
	logic        drq_next;
	logic        irq_reg;
	logic        irq_next;
	logic        lost_reg;
	logic        wprot_reg;
	logic        spin_end;
	logic        wr_take;
	logic [6:0]  half;
	logic [6:0]  hc_reg;
	logic        ph_reg;
	logic        seen_reg;
	logic [7:0]  rsh_reg;
	logic [2:0]  rbit_reg;
	logic        byte_done_reg;
	logic [7:0]  rbyte_reg;
	logic        rbit_val;

	fdc_enc_if enc_if ();

	fdc_sync #(.W(12), .RST(12'h800)) u_bus_sync (
		.clk_i  (clk_i),
		.nrst_i (nrst_i),
		.d_i    ({cs_n_i, rw_i, addr_i, host_data_lines_i}),
		.q_o    (bus_s)
	);

	fdc_sync #(.W(5), .RST(5'h1F)) u_drv_sync (
		.clk_i  (clk_i),
		.nrst_i (nrst_i),
		.d_i    ({raw_read_n_i, track_zero_sense_n_i, index_hole_sense_n_i,
		          write_protect_sense_n_i, density_select_i}),
		.q_o    (drv_s)
	);

	fdc_wenc u_wenc (
		.clk_i  (clk_i),
		.nrst_i (nrst_i),
		.enc    (enc_if.enc)
	);

	assign cs_n_s  = bus_s[11];
	assign rw_s    = bus_s[10];
	assign addr_s  = bus_s[9:8];
	assign din_s   = bus_s[7:0];
	assign raw_n_s = drv_s[4];
	assign trk0_hit  = !drv_s[3];
	assign index_hit = !drv_s[2];
	assign wp_n_s    = drv_s[1];
	assign mfm       = !drv_s[0];

	// one access per falling chip select; data is sampled alongside it
	assign acc     = cs_n_d_reg && !cs_n_s;
	// address zero splits status and command
	assign rd_stat = acc && rw_s && addr_s == fdc_pkg::ADDR_CMD_STAT;
	assign wr_cmd  = acc && !rw_s && addr_s == fdc_pkg::ADDR_CMD_STAT;
	assign rd_dat  = acc && rw_s && addr_s == fdc_pkg::ADDR_DATA;
	assign wr_dat  = acc && !rw_s && addr_s == fdc_pkg::ADDR_DATA;
	assign new_op  = din_s[7:4];
	// only a forced stop may interrupt a busy sequencer
	assign cmd_go  = wr_cmd && (state_reg == fdc_pkg::ST_IDLE || new_op == fdc_pkg::CMD_FORCE);
	assign op      = command_entry_reg[7:4];

	assign spin_end = state_reg == fdc_pkg::ST_SPIN && timer_reg == 20'h00000;
	assign wr_take  = state_reg == fdc_pkg::ST_WRITE && enc_if.take;

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			cs_n_d_reg  <= 1'b1;
			raw_n_d_reg <= 1'b1;
		end else begin
			cs_n_d_reg  <= cs_n_s;
			raw_n_d_reg <= raw_n_s;
		end
	end

	// head motion decision for the stepping commands
	always_comb begin
		need_step = 1'b0;
		dir_next  = dir_reg;
		case (op)
			fdc_pkg::CMD_RESTORE: begin
				need_step = !trk0_hit;
				dir_next  = 1'b0;
			end
			fdc_pkg::CMD_SEEK: begin
				need_step = head_track_number_reg != data_holding_reg;
				dir_next  = data_holding_reg > head_track_number_reg;
			end
			fdc_pkg::CMD_STEP_IN: begin
				need_step = !stepped_reg;
				dir_next  = 1'b1;
			end
			fdc_pkg::CMD_STEP_OUT: begin
				need_step = !stepped_reg;
				dir_next  = 1'b0;
			end
			default: begin
				need_step = 1'b0;
			end
		endcase
	end

	assign step_go = state_reg == fdc_pkg::ST_SETTLE && timer_reg == 20'h00000 && need_step;

	// sequencer
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			state_reg   <= fdc_pkg::ST_IDLE;
			timer_reg   <= 20'h00000;
			cnt_reg     <= 11'h000;
			stepped_reg <= 1'b0;
			dir_reg     <= 1'b0;
		end else if (cmd_go && new_op == fdc_pkg::CMD_FORCE) begin
			state_reg <= fdc_pkg::ST_DONE;
		end else begin
			case (state_reg)
				fdc_pkg::ST_IDLE: begin
					cnt_reg     <= 11'h000;
					stepped_reg <= 1'b0;
					// protected media refuses the write at once
					if (cmd_go && new_op == fdc_pkg::CMD_WRITE && !wp_n_s) begin
						state_reg <= fdc_pkg::ST_DONE;
					end else if (cmd_go) begin
						state_reg <= fdc_pkg::ST_SPIN;
						timer_reg <= 20'(SPINUP_CYC - 1);
					end
				end
				fdc_pkg::ST_SPIN: begin
					if (timer_reg != 20'h00000) begin
						timer_reg <= timer_reg - 20'h00001;
					end else if (op == fdc_pkg::CMD_READ) begin
						state_reg <= fdc_pkg::ST_READ;
					end else if (op == fdc_pkg::CMD_WRITE) begin
						state_reg <= fdc_pkg::ST_WRDRQ;
					end else begin
						state_reg <= fdc_pkg::ST_SETTLE;
					end
				end
				fdc_pkg::ST_SETTLE: begin
					if (timer_reg != 20'h00000) begin
						timer_reg <= timer_reg - 20'h00001;
					end else if (need_step) begin
						dir_reg   <= dir_next;
						state_reg <= fdc_pkg::ST_STEP;
						timer_reg <= 20'(fdc_pkg::STEP_PULSE_CYC - 1);
					end else begin
						state_reg <= fdc_pkg::ST_DONE;
					end
				end
				fdc_pkg::ST_STEP: begin
					stepped_reg <= 1'b1;
					if (timer_reg != 20'h00000) begin
						timer_reg <= timer_reg - 20'h00001;
					end else begin
						state_reg <= fdc_pkg::ST_SETTLE;
						timer_reg <= 20'(STEP_RATE_CYC - 1);
					end
				end
				fdc_pkg::ST_READ: begin
					if (byte_done_reg) begin
						cnt_reg <= cnt_reg + 11'h001;
						if (cnt_reg == 11'(SECTOR_BYTES - 1)) begin
							state_reg <= fdc_pkg::ST_DONE;
						end
					end
				end
				fdc_pkg::ST_WRDRQ: begin
					// gate stays off until the first byte is in
					if (!drq_reg) begin
						state_reg <= fdc_pkg::ST_WRITE;
					end
				end
				fdc_pkg::ST_WRITE: begin
					if (enc_if.take) begin
						cnt_reg <= cnt_reg + 11'h001;
						if (cnt_reg == 11'(SECTOR_BYTES)) begin
							state_reg <= fdc_pkg::ST_DONE;
						end
					end
				end
				fdc_pkg::ST_DONE: begin
					state_reg <= fdc_pkg::ST_IDLE;
				end
				default: begin
					state_reg <= fdc_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// track, sector, data and command registers
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			command_entry_reg        <= fdc_pkg::REG_RST;
			head_track_number_reg    <= fdc_pkg::REG_RST;
			target_sector_number_reg <= fdc_pkg::REG_RST;
			data_holding_reg         <= fdc_pkg::REG_RST;
		end else begin
			if (cmd_go) begin
				command_entry_reg <= din_s;
			end
			if (step_go) begin
				head_track_number_reg <= dir_next ? head_track_number_reg + 8'h01
				                                  : head_track_number_reg - 8'h01;
			end else if (state_reg == fdc_pkg::ST_SETTLE && op == fdc_pkg::CMD_RESTORE && trk0_hit) begin
				head_track_number_reg <= 8'h00;
			end else if (acc && !rw_s && addr_s == fdc_pkg::ADDR_TRACK) begin
				head_track_number_reg <= din_s;
			end
			if (acc && !rw_s && addr_s == fdc_pkg::ADDR_SECTOR) begin
				target_sector_number_reg <= din_s;
			end
			// disk bytes win over a late host write
			if (byte_done_reg) begin
				data_holding_reg <= rbyte_reg;
			end else if (wr_dat) begin
				data_holding_reg <= din_s;
			end
		end
	end

	// data request; hardware set beats the host clear
	always_comb begin
		drq_next = drq_reg;
		// host read empties the register, also once the sector has ended
		if (rd_dat && op == fdc_pkg::CMD_READ) begin
			drq_next = 1'b0;
		end
		if (wr_dat && (state_reg == fdc_pkg::ST_WRDRQ || state_reg == fdc_pkg::ST_WRITE)) begin
			drq_next = 1'b0;
		end
		// a finished read leaves its last byte pending for the host
		if ((state_reg == fdc_pkg::ST_DONE && op != fdc_pkg::CMD_READ) || cmd_go) begin
			drq_next = 1'b0;
		end
		if (byte_done_reg || (spin_end && op == fdc_pkg::CMD_WRITE)) begin
			drq_next = 1'b1;
		end
		// no request once the last byte is in the shifter
		if (wr_take && cnt_reg < 11'(SECTOR_BYTES - 1)) begin
			drq_next = 1'b1;
		end
	end

	// cleared by status read or command load
	always_comb begin
		irq_next = irq_reg;
		if (rd_stat || wr_cmd) begin
			irq_next = 1'b0;
		end
		// set on completion, wins over the clear
		if (state_reg == fdc_pkg::ST_DONE) begin
			irq_next = 1'b1;
		end
	end

	// flags return to their initial state
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			drq_reg   <= 1'b0;
			irq_reg   <= 1'b0;
			lost_reg  <= 1'b0;
			wprot_reg <= 1'b0;
		end else begin
			drq_reg <= drq_next;
			irq_reg <= irq_next;
			if (cmd_go) begin
				lost_reg  <= 1'b0;
				// write protect sampled as the command arrives
				wprot_reg <= new_op == fdc_pkg::CMD_WRITE && !wp_n_s;
			end else if ((byte_done_reg && drq_reg) || (wr_take && drq_reg)) begin
				lost_reg <= 1'b1;
			end
		end
	end

	// bit recovery from falling raw pulses; coarse window, no pll
	assign half     = mfm ? fdc_pkg::MFM_HALF_CYC : fdc_pkg::FM_HALF_CYC;
	assign rbit_val = seen_reg || (raw_n_d_reg && !raw_n_s);

	always_ff @(posedge clk_i) begin
		if (!nrst_i || state_reg != fdc_pkg::ST_READ) begin
			hc_reg        <= 7'h00;
			ph_reg        <= 1'b0;
			seen_reg      <= 1'b0;
			rsh_reg       <= 8'h00;
			rbit_reg      <= 3'h0;
			byte_done_reg <= 1'b0;
			rbyte_reg     <= 8'h00;
		end else begin
			byte_done_reg <= 1'b0;
			if (raw_n_d_reg && !raw_n_s && !ph_reg) begin
				// pulse in the clock window recentres the cell
				hc_reg <= half >> 1;
			end else if (hc_reg == half - 7'h01) begin
				hc_reg <= 7'h00;
				ph_reg <= !ph_reg;
				if (ph_reg) begin
					rsh_reg  <= {rsh_reg[6:0], rbit_val};
					rbit_reg <= rbit_reg + 3'h1;
					if (rbit_reg == 3'h7) begin
						byte_done_reg <= 1'b1;
						rbyte_reg     <= {rsh_reg[6:0], rbit_val};
					end
				end
			end else begin
				hc_reg <= hc_reg + 7'h01;
			end
			if (hc_reg == half - 7'h01 && ph_reg) begin
				seen_reg <= 1'b0;
			end else if (raw_n_d_reg && !raw_n_s && ph_reg) begin
				seen_reg <= 1'b1;
			end
		end
	end

	// encoder gets the next byte, zero when the host was late
	assign enc_if.mfm       = mfm;
	assign enc_if.next_byte = drq_reg ? 8'h00 : data_holding_reg;
	// encoder runs only once the gate is already up
	assign enc_if.en        = write_gate_o && state_reg == fdc_pkg::ST_WRITE;

	always_comb begin
		host_status                    = 8'h00;
		host_status[fdc_pkg::ST_BUSY]  = state_reg != fdc_pkg::ST_IDLE;
		host_status[fdc_pkg::ST_DRQ]   = drq_reg;
		host_status[fdc_pkg::ST_LOST]  = lost_reg;
		host_status[fdc_pkg::ST_TRK0]  = trk0_hit;
		host_status[fdc_pkg::ST_INDEX] = index_hit;
		host_status[fdc_pkg::ST_WPROT] = wprot_reg;
		host_status[fdc_pkg::ST_MOTOR] = spindle_enable_o;
	end

	// pin outputs, all from flops
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			host_data_lines_o    <= 8'h00;
			host_data_lines_oe_o <= 1'b0;
			step_o               <= 1'b0;
			head_direction_o     <= 1'b0;
			spindle_enable_o     <= 1'b0;
			write_gate_o         <= 1'b0;
			disk_write_pulses_o  <= 1'b0;
		end else begin
			case (addr_s)
				fdc_pkg::ADDR_CMD_STAT: host_data_lines_o <= host_status;
				fdc_pkg::ADDR_TRACK:    host_data_lines_o <= head_track_number_reg;
				fdc_pkg::ADDR_SECTOR:   host_data_lines_o <= target_sector_number_reg;
				default:                host_data_lines_o <= data_holding_reg;
			endcase
			// drive only while selected for a read
			host_data_lines_oe_o <= !cs_n_s && rw_s;
			step_o               <= state_reg == fdc_pkg::ST_STEP;
			// direction settles a cycle ahead of the step pulse
			head_direction_o     <= step_go ? dir_next : dir_reg;
			// motor on from spin-up to completion
			spindle_enable_o     <= state_reg != fdc_pkg::ST_IDLE && state_reg != fdc_pkg::ST_DONE;
			write_gate_o         <= state_reg == fdc_pkg::ST_WRITE;
			disk_write_pulses_o  <= enc_if.pulse;
		end
	end

	assign data_request_flag_o = drq_reg;
	assign command_done_irq_o  = irq_reg;
endmodule : fdc_top

// ===== fdc_drive.sv
// fdc_drive: behavioural floppy drive facing the controller pins
`timescale 1ns/1ps
module fdc_drive (
	input  wire logic clk_i,
	input  wire logic step_i,
	input  wire logic dir_i,
	input  wire logic motor_i,
	input  wire logic dens_i,
	output logic      raw_read_n_o,
	output logic      trk0_n_o,
	output logic      index_n_o,
	output int        pos_o
);
	int ph = 0;
	bit step_d = 1'b0;
	initial pos_o = 0;
	// head moves once per rising step, never past the outer stop
	always @(posedge clk_i) begin
		step_d <= step_i;
		ph <= motor_i ? (ph + 1) % 1600 : 0;
		if (step_i && !step_d) begin
			pos_o <= dir_i ? pos_o + 1 : (pos_o > 0 ? pos_o - 1 : 0);
		end
	end
	// flux pulses low, one per half cell of the selected density
	assign raw_read_n_o = !(motor_i && ph % (dens_i ? 80 : 40) < 4);
	assign trk0_n_o = (pos_o != 0);
	// index hole low; pull-up while stopped
	assign index_n_o = !(motor_i && ph < 10);
endmodule : fdc_drive

// ===== fdc_top_chk.sv
// fdc_top_chk: pin level assertions for the floppy controller
`timescale 1ns/1ps
module fdc_top_chk (
	input wire logic       clk_i,
	input wire logic       nrst_i,
	input wire logic       cs_n_i,
	input wire logic       rw_i,
	input wire logic [1:0] addr_i,
	input wire logic       host_data_lines_oe_o,
	input wire logic       command_done_irq_o,
	input wire logic       step_o,
	input wire logic       head_direction_o,
	input wire logic       spindle_enable_o,
	input wire logic       write_gate_o,
	input wire logic       disk_write_pulses_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	int stp_len;
	// high time of the current step pulse
	always_ff @(posedge clk_i) begin
		if (!nrst_i || !step_o) stp_len <= 0;
		else stp_len <= stp_len + 1;
	end
	sequence s_idle; cs_n_i [*4]; endsequence
	sequence s_sel_rd; (!cs_n_i && rw_i) [*4]; endsequence
	sequence s_stat_rd; (!cs_n_i && rw_i && addr_i == 2'h0) [*4]; endsequence
	property p_idle_off; s_idle |=> !host_data_lines_oe_o; endproperty
	a_idle_off: assert property (p_idle_off) else $error("bus driven while deselected");
	property p_rd_on; s_sel_rd |=> host_data_lines_oe_o; endproperty
	a_rd_on: assert property (p_rd_on) else $error("selected read not driven");
	property p_wr_off; (!rw_i) [*4] |=> !host_data_lines_oe_o; endproperty
	a_wr_off: assert property (p_wr_off) else $error("bus driven in write cycle");
	property p_stat_clr; s_stat_rd |=> !command_done_irq_o; endproperty
	a_stat_clr: assert property (p_stat_clr) else $error("irq kept after status read");
	property p_dir_hold; step_o |-> $stable(head_direction_o); endproperty
	a_dir_hold: assert property (p_dir_hold) else $error("direction moved during step");
	property p_step_len; $fell(step_o) |-> stp_len == fdc_pkg::STEP_PULSE_CYC; endproperty
	a_step_len: assert property (p_step_len) else $error("step pulse width wrong");
	property p_step_mot; step_o |-> spindle_enable_o; endproperty
	a_step_mot: assert property (p_step_mot) else $error("step without motor");
	property p_mot_lead; $rose(spindle_enable_o) |-> (!step_o && !write_gate_o) [*8]; endproperty
	a_mot_lead: assert property (p_mot_lead) else $error("no spin-up before operation");
	property p_gate_mot; write_gate_o |-> spindle_enable_o; endproperty
	a_gate_mot: assert property (p_gate_mot) else $error("write gate without motor");
	property p_wd_gate; disk_write_pulses_o |-> write_gate_o; endproperty
	a_wd_gate: assert property (p_wd_gate) else $error("write pulse without gate");
endmodule : fdc_top_chk

// ===== fdc_top_test.sv
// fdc_top_test: self-checking bench for the floppy controller pins
`timescale 1ns/1ps
module fdc_top_test;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic cs_n = 1'b1;
	logic rw = 1'b1;
	logic [1:0] addr = 2'h0;
	logic [7:0] din = 8'h00;
	logic dens = 1'b0;
	logic wp_n = 1'b1;
	logic [7:0] dout;
	logic oe, data_request_flag, irq, stp, dir, mot, wg, wd, rd_n, t0_n, ix_n;
	logic [7:0] r, q, tv;
	logic [31:0] seed = 32'h0000447D;
	logic [3:0] ops [6] = '{4'h2, 4'h2, 4'h3, 4'h0, 4'h1, 4'hD};
	int fails = 0;
	int checks_done = 0;
	int cyc = 0;
	int npulse = 0;
	int pos, ep;
	bit spun = 1'b0;
	always #25 clk_i = ~clk_i;
	fdc_top #(.STEP_RATE_CYC(50), .SPINUP_CYC(20), .SECTOR_BYTES(2)) dut_u (.clk_i(clk_i), .nrst_i(nrst_i),
		.cs_n_i(cs_n), .rw_i(rw), .addr_i(addr), .host_data_lines_i(din), .host_data_lines_o(dout),
		.host_data_lines_oe_o(oe), .data_request_flag_o(data_request_flag), .command_done_irq_o(irq), .step_o(stp),
		.head_direction_o(dir), .spindle_enable_o(mot), .write_gate_o(wg), .disk_write_pulses_o(wd),
		.raw_read_n_i(rd_n), .track_zero_sense_n_i(t0_n), .index_hole_sense_n_i(ix_n),
		.write_protect_sense_n_i(wp_n), .density_select_i(dens));
	fdc_drive drv_u (.clk_i(clk_i), .step_i(stp), .dir_i(dir), .motor_i(mot), .dens_i(dens), .raw_read_n_o(rd_n),
		.trk0_n_o(t0_n), .index_n_o(ix_n), .pos_o(pos));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [7:0] exp_trk(input logic [7:0] t, input logic [3:0] op);
		case (op)
			4'h0: return 8'h00;
			4'h1: return 8'h03;
			4'h2: return t + 8'h01;
			4'h3: return t - 8'h01;
			default: return t;
		endcase
	endfunction : exp_trk
	function automatic int exp_pos(input int p, input logic [3:0] op);
		case (op)
			4'h0: return 0;
			4'h1: return 3;
			4'h2: return p + 1;
			4'h3: return p - 1;
			default: return p;
		endcase
	endfunction : exp_pos
	task finish_test;
		$display("checks %0d errors %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : finish_test
	task chk8(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk8
	// one host access; the device has no ready, so hold a fixed time
	task acc(input logic w_n, input logic [1:0] a, input logic [7:0] d, output logic [7:0] rq);
		@(posedge clk_i);
		cs_n <= 1'b0;
		rw <= w_n;
		addr <= a;
		din <= d;
		repeat (5) @(posedge clk_i);
		#1 rq = dout;
		@(posedge clk_i);
		cs_n <= 1'b1;
		repeat (4) @(posedge clk_i);
	endtask : acc
	task wsig(input bit d);
		int n;
		n = 0;
		while ((d ? data_request_flag : irq) !== 1'b1 && n < 20000) begin
			@(posedge clk_i);
			n++;
		end
		#1;
		if (n >= 20000) fails++;
	endtask : wsig
	// issue a command, serve n data bytes, then collect completion
	task cmd(input logic [3:0] op, input int n, input bit wr);
		acc(1'b0, 2'h0, {op, 4'h0}, q);
		for (int k = 0; k < n; k++) begin
			wsig(1'b1);
			seed = lfsr(seed);
			acc(!wr, 2'h3, seed[7:0], q);
			chk8({7'h00, data_request_flag}, {7'h00, wr && k < n - 1});
		end
		wsig(1'b0);
		chk8({7'h00, irq}, 8'h01);
		acc(1'b1, 2'h0, 8'h00, r);
		chk8({7'h00, irq}, 8'h00);
	endtask : cmd
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (mot === 1'b1) spun <= 1'b1;
		if (wd === 1'b1) npulse <= npulse + 1;
		if (cyc == 40000) begin
			fails++;
			finish_test();
		end
	end
	initial begin
		repeat (10) @(posedge clk_i);
		nrst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		#1;
		chk8({oe, data_request_flag, irq, stp, mot, wg, wd, dir}, 8'h00);
		acc(1'b1, 2'h0, 8'h00, r);
		chk8(r & 8'hF7, 8'h00);
		chk8(r & 8'h08, 8'h08);
		for (int a = 1; a < 4; a++) begin
			seed = lfsr(seed);
			if (a == 1) tv = seed[7:0];
			acc(1'b0, a[1:0], seed[7:0], q);
			acc(1'b1, a[1:0], 8'h00, r);
			chk8(r, seed[7:0]);
		end
		@(posedge clk_i);
		rw <= 1'b0;
		din <= ~tv;
		addr <= 2'h1;
		repeat (8) @(posedge clk_i);
		acc(1'b1, 2'h1, 8'h00, r);
		chk8(r, tv);
		acc(1'b0, 2'h3, 8'h03, q);
		ep = 0;
		for (int i = 0; i < 6; i++) begin
			cmd(ops[i], 0, 1'b0);
			tv = exp_trk(tv, ops[i]);
			ep = exp_pos(ep, ops[i]);
			acc(1'b1, 2'h1, 8'h00, r);
			chk8(r, tv);
			chk8(8'(pos), 8'(ep));
		end
		for (int d = 0; d < 2; d++) begin
			dens <= d[0];
			cmd(4'h8, 2, 1'b0);
		end
		wp_n <= 1'b0;
		spun = 1'b0;
		cmd(4'hA, 0, 1'b1);
		chk8(r & 8'h40, 8'h40);
		chk8({7'h00, spun}, 8'h00);
		wp_n <= 1'b1;
		npulse = 0;
		cmd(4'hA, 2, 1'b1);
		chk8({7'h00, npulse > 0}, 8'h01);
		finish_test();
	end
endmodule : fdc_top_test
bind fdc_top fdc_top_chk chk_u (.clk_i(clk_i), .nrst_i(nrst_i), .cs_n_i(cs_n_i), .rw_i(rw_i), .addr_i(addr_i),
	.host_data_lines_oe_o(host_data_lines_oe_o), .command_done_irq_o(command_done_irq_o), .step_o(step_o),
	.head_direction_o(head_direction_o), .spindle_enable_o(spindle_enable_o), .write_gate_o(write_gate_o),
	.disk_write_pulses_o(disk_write_pulses_o));
